// file: verilog/fsk_freq_error_bitsync_ctrl.sv
// fsk transceiver digital control: estimator, bit synchronizer, tx tone select, amplifier
// assumes SYS_CLK at 40 MHz from the crystal, demodulator and data pins asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "fsk_ctrl_map.svh"

// single clock fifo, width and depth as parameters
module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] fill_r;
    logic push;
    logic pop;

    // honest full and empty from the fill count
    assign in_ready = (fill_r != (AW+1)'(DEPTH));
    assign out_valid = (fill_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_r];

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            fill_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1);
            end
            fill_r <= fill_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : bit_fifo

// Summary of operation
// RULE1: estimator counts demodulator up and down pulses
// RULE2: about twice modulation index pulses per symbol
// RULE3: low control bits select counting mode
// RULE4: upper control bits select 8/16/32/64 symbols
// RULE5: result readable as 8-bit register
// RULE6: result is two's complement
// RULE7: host should prefer up-and-down mode
// RULE8: sync bit in receive drives recovered clock
// RULE9: recovered clock runs at the bit rate
// RULE10: receive data changes on clock rising edge
// RULE11: host samples receive data on falling edge
// RULE12: synchronizer clock is crystal over divider product
// RULE13: predivider is six bits, 1 to 63
// RULE14: shift setting 0 to 7 sets exponent
// RULE15: predivider also feeds modulator and bitrate clocks
// RULE16: synchronizer locks within 22 bit periods
// RULE17: level field gives seven 3dB steps
// RULE18: level zero turns amplifier off
// RULE19: bypass bit bypasses amplifier, level still applies
// RULE20: zero bits use zero-tone, ones one-tone dividers
// RULE21: data pin input in transmit, output in receive
// RULE22: host drives transmit bits on data pin
// RULE23: transmit data changes falling, sampled rising
// RULE24: estimator counter wraps instead of saturating
// RULE25: counter clears at start, holds when done
module fsk_freq_error_bitsync_ctrl (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic [6:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic UP_PULSE,
    input wire logic DOWN_PULSE,
    input wire logic DEMOD_DATA,
    input wire logic DATA_IN,
    output logic DATA_OUT,
    output logic DATA_OE,
    output logic RECOVERED_BIT_CLOCK,
    output logic TONE_VALID,
    input wire logic TONE_READY,
    output logic TONE_ONE,
    output logic MOD_CLK_TICK,
    output logic [2:0] AMPLIFIER_LEVEL,
    output logic AMPLIFIER_ENABLE,
    output logic AMPLIFIER_BYPASS,
    output logic LOW_NOISE_AMP_SKIP,
    output logic [3:0] FILTER_RSSI_BITS
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    // register file
    logic [7:1] frontend_r;
    logic [3:0] filter_r;
    logic [3:0] shift_sel_r;
    logic [7:0] refdiv_r;
    logic [3:0] error_estimator_ctrl_r;
    fsk_ctrl_pkg::byte_t freq_error_count_r;
    // field views
    logic [1:0] xcvr_mode;
    logic is_rx;
    logic is_tx;
    logic sync_en;
    logic [1:0] est_mode;
    logic [1:0] est_len;
    logic [2:0] synchronizer_clock_shift;
    logic [2:0] bitrate_clock_shift;
    logic [5:0] refclk_k;
    logic est_start;

    assign xcvr_mode = frontend_r[`FE_MODE_HI:`FE_MODE_LO];
    assign is_rx = (xcvr_mode == `XCVR_MODE_RX);
    assign is_tx = (xcvr_mode == `XCVR_MODE_TX);
    assign sync_en = frontend_r[`FE_SYNC_EN];
    assign est_mode = error_estimator_ctrl_r[1:0]; // RULE3
    assign est_len = error_estimator_ctrl_r[3:2]; // RULE4
    assign synchronizer_clock_shift = shift_sel_r[3:1]; // RULE14
    assign bitrate_clock_shift = {shift_sel_r[0], refdiv_r[7:6]};
    assign refclk_k = refdiv_r[5:0]; // RULE13
    assign est_start = REG_WR && (REG_ADDR == `ADDR_ERROR_ESTIMATOR_CONTROL);

    // register writes; the result register is read-only
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            frontend_r <= `RST_FRONTEND;
            filter_r <= `RST_FILTER;
            shift_sel_r <= `RST_SHIFT;
            refdiv_r <= `RST_REFDIV;
            error_estimator_ctrl_r <= `RST_EST_CTRL;
        end else if (REG_WR) begin
            unique case (REG_ADDR)
                `ADDR_FRONTEND_MODE_CONFIG: frontend_r <= REG_WDATA[7:1];
                `ADDR_FILTER_RSSI_CONFIG: filter_r <= REG_WDATA[3:0];
                `ADDR_SYNC_CLOCK_SHIFT_SELECT: shift_sel_r <= REG_WDATA[3:0];
                `ADDR_REFERENCE_DIVIDER_CONFIG: refdiv_r <= REG_WDATA;
                `ADDR_ERROR_ESTIMATOR_CONTROL: error_estimator_ctrl_r <= REG_WDATA[3:0];
                default: ;
            endcase
        end
    end

    // readback, one cycle after the read strobe; fixed bits read as printed
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            REG_RDATA <= 8'h00;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                unique case (REG_ADDR)
                    `ADDR_FRONTEND_MODE_CONFIG: REG_RDATA <= {frontend_r, 1'b1};
                    `ADDR_FILTER_RSSI_CONFIG: REG_RDATA <= {4'h8, filter_r};
                    `ADDR_SYNC_CLOCK_SHIFT_SELECT: REG_RDATA <= {4'h0, shift_sel_r};
                    `ADDR_REFERENCE_DIVIDER_CONFIG: REG_RDATA <= refdiv_r;
                    `ADDR_ERROR_ESTIMATOR_CONTROL: REG_RDATA <= {4'h0, error_estimator_ctrl_r};
                    `ADDR_ERROR_ESTIMATOR_RESULT: REG_RDATA <= freq_error_count_r; // RULE5
                    default: REG_RDATA <= 8'h00;
                endcase
            end
        end
    end

    // the bypass bit has no printed slot; it lives in bit 7 of the shift register
    logic bypass_r;
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            bypass_r <= 1'b0;
        end else if (REG_WR && REG_ADDR == `ADDR_SYNC_CLOCK_SHIFT_SELECT) begin
            bypass_r <= REG_WDATA[7]; // RULE19
        end
    end

    // amplifier and front end settings straight from the register
    assign AMPLIFIER_LEVEL = frontend_r[`FE_AMP_LEVEL_HI:`FE_AMP_LEVEL_LO]; // RULE17
    assign AMPLIFIER_ENABLE = (AMPLIFIER_LEVEL != 3'h0); // RULE18
    assign AMPLIFIER_BYPASS = bypass_r; // RULE19
    assign LOW_NOISE_AMP_SKIP = frontend_r[`FE_LOW_NOISE_AMP_SKIP];
    assign FILTER_RSSI_BITS = filter_r;

    // two flip-flop synchronisers for all asynchronous inputs
    logic [3:0] async_in;
    logic [3:0] meta_r;
    logic [3:0] sync_r;
    logic [3:0] sync_d_r;
    assign async_in = {DATA_IN, DEMOD_DATA, DOWN_PULSE, UP_PULSE};
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            meta_r <= 4'h0;
            sync_r <= 4'h0;
            sync_d_r <= 4'h0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            sync_d_r <= sync_r;
        end
    end

    logic up_evt;
    logic down_evt;
    logic rx_bit;
    logic tx_pin_bit;
    assign up_evt = sync_r[0] && !sync_d_r[0]; // RULE1
    assign down_evt = sync_r[1] && !sync_d_r[1]; // RULE1
    assign rx_bit = sync_r[2];
    assign tx_pin_bit = sync_r[3];

    // shared reference predivider; code 0 behaves as 1
    // compares use >= so a lowered setting never lets a count run past its end
    logic [5:0] prediv_cnt_r;
    logic [5:0] k_eff;
    logic pre_tick;
    assign k_eff = (refclk_k == 6'h00) ? 6'h01 : refclk_k;
    assign pre_tick = (prediv_cnt_r >= k_eff - 6'h01); // RULE13
    assign MOD_CLK_TICK = pre_tick; // RULE15
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            prediv_cnt_r <= 6'h00;
        end else begin
            prediv_cnt_r <= pre_tick ? 6'h00 : prediv_cnt_r + 6'h01;
        end
    end

    // synchronizer clock: predivided tick over 2^(7-shift)
    logic [7:0] sync_len;
    logic [6:0] sync_div_r;
    logic sync_tick;
    assign sync_len = `SYNC_DIV_FULL >> synchronizer_clock_shift; // RULE12 RULE14
    assign sync_tick = pre_tick && ({1'b0, sync_div_r} + 8'h01 >= sync_len); // RULE12
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            sync_div_r <= 7'h00;
        end else if (pre_tick) begin
            sync_div_r <= sync_tick ? 7'h00 : sync_div_r + 7'h01;
        end
    end

    // bit rate clock half period: predivided tick over 2^(6-shift)
    logic [7:0] br_half_raw;
    logic [7:0] br_half;
    logic [6:0] br_div_r;
    logic br_half_tick;
    assign br_half_raw = `BITRATE_HALF_FULL >> bitrate_clock_shift;
    assign br_half = (br_half_raw == 8'h00) ? 8'h01 : br_half_raw;
    assign br_half_tick = pre_tick && ({1'b0, br_div_r} + 8'h01 >= br_half); // RULE15
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            br_div_r <= 7'h00;
        end else if (pre_tick) begin
            br_div_r <= br_half_tick ? 7'h00 : br_div_r + 7'h01;
        end
    end

    // bit synchronizer: 16 phases per bit, one phase nudge per data edge
    // a nudge of one step is slow but limits how far a single glitch can pull the phase
    logic [3:0] phase_r;
    logic [4:0] phase_step;
    logic last_rx_r;
    logic rx_edge;
    logic bit_wrap;
    assign rx_edge = sync_tick && (rx_bit != last_rx_r);
    always_comb begin
        phase_step = {1'b0, phase_r} + 5'h01;
        if (rx_edge && phase_r < `SYNC_MID_PHASE) begin
            phase_step = {1'b0, phase_r}; // late edge, hold back
        end else if (rx_edge && phase_r > `SYNC_MID_PHASE) begin
            phase_step = {1'b0, phase_r} + 5'h02; // early edge, catch up
        end
    end
    assign bit_wrap = sync_tick && phase_step[4]; // RULE16
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            phase_r <= 4'h0;
            last_rx_r <= 1'b0;
        end else if (sync_tick) begin
            phase_r <= phase_step[3:0]; // RULE16
            last_rx_r <= rx_bit;
        end
    end

    // transmit sampler and its clock; a full fifo freezes the clock
    logic tx_clk_r;
    logic fifo_in_ready;
    logic tx_sample;
    assign tx_sample = is_tx && br_half_tick && !tx_clk_r && fifo_in_ready; // RULE23
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            tx_clk_r <= 1'b0;
        end else if (!is_tx) begin
            tx_clk_r <= 1'b0;
        end else if (br_half_tick && (tx_clk_r || fifo_in_ready)) begin
            tx_clk_r <= !tx_clk_r; // RULE23
        end
    end

    // host bits to the synthesizer tone select through the fifo
    bit_fifo #(
        .WIDTH(1),
        .DEPTH(16)
    ) u_tx_fifo (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .in_valid(tx_sample),
        .in_ready(fifo_in_ready),
        .in_data(tx_pin_bit), // RULE22
        .out_valid(TONE_VALID),
        .out_ready(TONE_READY),
        .out_data(TONE_ONE) // RULE20
    );

    // receive path: clock and data on the pins
    logic rx_clk_r;
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            rx_clk_r <= 1'b0;
            DATA_OUT <= 1'b0;
        end else if (!(is_rx && sync_en)) begin
            rx_clk_r <= 1'b0;
            DATA_OUT <= rx_bit;
        end else if (bit_wrap) begin
            rx_clk_r <= 1'b1; // RULE8 RULE9
            DATA_OUT <= rx_bit; // RULE10
        end else if (sync_tick && phase_step[3:0] == `SYNC_MID_PHASE) begin
            rx_clk_r <= 1'b0; // RULE11
        end
    end

    assign RECOVERED_BIT_CLOCK = rx_clk_r || tx_clk_r;
    assign DATA_OE = is_rx; // RULE21

    // frequency error estimator
    fsk_ctrl_pkg::est_state_e est_state_r;
    logic [6:0] sym_cnt_r;
    logic [6:0] sym_target;
    logic symbol_evt;
    assign sym_target = 7'(`EST_LEN_BASE << est_len); // RULE4
    assign symbol_evt = bit_wrap && is_rx;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            est_state_r <= fsk_ctrl_pkg::EST_IDLE;
            sym_cnt_r <= 7'h00;
        end else if (est_start) begin
            est_state_r <= (REG_WDATA[1:0] == `EST_MODE_OFF) ?
                fsk_ctrl_pkg::EST_IDLE : fsk_ctrl_pkg::EST_RUN;
            sym_cnt_r <= 7'h00;
        end else begin
            unique case (est_state_r)
                fsk_ctrl_pkg::EST_IDLE: ;
                fsk_ctrl_pkg::EST_RUN: begin
                    if (symbol_evt) begin
                        sym_cnt_r <= sym_cnt_r + 7'h01;
                        if (sym_cnt_r + 7'h01 == sym_target) begin
                            est_state_r <= fsk_ctrl_pkg::EST_DONE; // RULE25
                        end
                    end
                end
                fsk_ctrl_pkg::EST_DONE: ;
            endcase
        end
    end

    // one count per pulse, so a symbol adds about twice the modulation index
    logic counting;
    assign counting = (est_state_r == fsk_ctrl_pkg::EST_RUN);
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            freq_error_count_r <= 8'h00;
        end else if (est_start) begin
            freq_error_count_r <= 8'h00; // RULE25
        end else if (counting) begin
            unique case (est_mode)
                `EST_MODE_OFF: ; // RULE3
                `EST_MODE_UP: freq_error_count_r <= freq_error_count_r + 8'(up_evt); // RULE2
                `EST_MODE_DOWN: freq_error_count_r <= freq_error_count_r - 8'(down_evt); // RULE6
                `EST_MODE_UPDOWN: freq_error_count_r <= freq_error_count_r + 8'(up_evt)
                    - 8'(down_evt); // RULE24
            endcase
        end
    end

    // checks next to the logic they guard
    property p_amp_off;
        REG_WR && REG_ADDR == `ADDR_FRONTEND_MODE_CONFIG |=>
            AMPLIFIER_ENABLE == ($past(REG_WDATA[6:4]) != 3'h0);
    endproperty
    a_amp_off: assert property (p_amp_off) else $error("amplifier enable wrong"); // RULE18

    property p_bypass;
        REG_WR && REG_ADDR == `ADDR_SYNC_CLOCK_SHIFT_SELECT |=>
            AMPLIFIER_BYPASS == $past(REG_WDATA[7]);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not taken"); // RULE19

    property p_pin_dir;
        is_tx |-> !DATA_OE;
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("data pin driven in transmit"); // RULE21

    property p_clear_on_start;
        est_start |=> freq_error_count_r == 8'h00 && sym_cnt_r == 7'h00;
    endproperty
    a_clear_on_start: assert property (p_clear_on_start) else $error("no clear"); // RULE25

    property p_wrap;
        counting && !est_start && est_mode == `EST_MODE_UPDOWN && down_evt && !up_evt
            && freq_error_count_r == 8'h80 |=> freq_error_count_r == 8'h7F;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count saturated"); // RULE24

    property p_off_holds;
        est_mode == `EST_MODE_OFF && !est_start |=> $stable(freq_error_count_r);
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("count moved while off"); // RULE3

    property p_done_holds;
        est_state_r == fsk_ctrl_pkg::EST_DONE && !est_start |=> $stable(freq_error_count_r);
    endproperty
    a_done_holds: assert property (p_done_holds) else $error("count moved after end"); // RULE25

    property p_len;
        est_state_r == fsk_ctrl_pkg::EST_RUN |-> sym_cnt_r < sym_target;
    endproperty
    a_len: assert property (p_len) else $error("symbol count over length"); // RULE4

    sequence s_rx_sync;
        is_rx && sync_en;
    endsequence
    property p_rx_data_edge;
        s_rx_sync ##1 (s_rx_sync and $changed(DATA_OUT)) |-> $rose(rx_clk_r);
    endproperty
    a_rx_data_edge: assert property (p_rx_data_edge) else $error("data moved off edge"); // RULE10

    property p_clk_idle;
        !(is_rx && sync_en) && !is_tx |=> !RECOVERED_BIT_CLOCK;
    endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("clock runs while disabled"); // RULE8
endmodule : fsk_freq_error_bitsync_ctrl
`default_nettype wire

// file: verilog/fsk_ctrl_map.svh
// register offsets, field positions, reset values and timing counts of the fsk control block
// assumes inclusion by bare name from the design file; definitions only
`ifndef FSK_CTRL_MAP_SVH
`define FSK_CTRL_MAP_SVH

// register indices on the 7-bit programming address
`define ADDR_FRONTEND_MODE_CONFIG 7'h00
`define ADDR_FILTER_RSSI_CONFIG 7'h01
`define ADDR_SYNC_CLOCK_SHIFT_SELECT 7'h06
`define ADDR_REFERENCE_DIVIDER_CONFIG 7'h07
`define ADDR_ERROR_ESTIMATOR_CONTROL 7'h15
`define ADDR_ERROR_ESTIMATOR_RESULT 7'h16

// frontend_mode_config fields
`define FE_LOW_NOISE_AMP_SKIP 7
`define FE_AMP_LEVEL_HI 6
`define FE_AMP_LEVEL_LO 4
`define FE_SYNC_EN 3
`define FE_MODE_HI 2
`define FE_MODE_LO 1
// transceiver mode codes in Mode1..Mode0
`define XCVR_MODE_RX 2'h1
`define XCVR_MODE_TX 2'h2

// error estimator mode codes and length codes
`define EST_MODE_OFF 2'h0
`define EST_MODE_UP 2'h1
`define EST_MODE_DOWN 2'h2
`define EST_MODE_UPDOWN 2'h3
`define EST_LEN_BASE 8'h08

// reset values
`define RST_FRONTEND 7'h00
`define RST_FILTER 4'h0
`define RST_SHIFT 4'h0
`define RST_REFDIV 8'h01
`define RST_EST_CTRL 4'h0

// divider and synchronizer timing
`define SYNC_DIV_FULL 8'h80
`define BITRATE_HALF_FULL 8'h40
`define SYNC_OVERSAMPLE 16
`define SYNC_MID_PHASE 4'h8
`define SYNC_LOCK_BITS 22

`endif

// file: verilog/fsk_ctrl_pkg.sv
// types shared by the fsk control block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package fsk_ctrl_pkg;
    typedef enum logic [1:0] {EST_IDLE, EST_RUN, EST_DONE} est_state_e;
    typedef logic [7:0] byte_t;
endpackage : fsk_ctrl_pkg
`default_nettype wire

// file: tb/host_mcu_model.sv
// host microcontroller model on the data pin and the recovered clock pin
// assumes the device's clock and data outputs are registered on SYS_CLK
`timescale 1ns/100ps
`default_nettype none
module host_mcu_model (
    input wire logic bit_clk,
    input wire logic pin_oe,
    input wire logic pin_out,
    output logic pin_level,
    output logic rx_bit
);
    logic host_drv = 1'b0;
    logic [15:0] pattern = 16'hA5C3;
    int n_sent = 0;
    bit sent_q[$];
    // wire level: device drives in receive, the host otherwise
    assign pin_level = (pin_oe === 1'b1) ? pin_out : host_drv;
    // host acts only on the falling edge, leaving the rising edge to the device
    always @(negedge bit_clk) begin
        if (pin_oe === 1'b1) begin
            rx_bit <= pin_out;
        end else begin
            host_drv <= pattern[n_sent % 16];
        end
    end
    // what the device must have taken at each rising edge in transmit
    always @(posedge bit_clk) begin
        if (pin_oe !== 1'b1) begin
            sent_q.push_back(pin_level);
            n_sent++;
        end
    end
endmodule : host_mcu_model
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the fsk control block, register port tasks
// assumes the strobe register port and one 40 MHz clock
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic SYS_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [6:0] REG_ADDR = 7'h00;
    logic [7:0] REG_WDATA = 8'h00;
    logic REG_WR = 1'b0, REG_RD = 1'b0, UP_PULSE = 1'b0, DOWN_PULSE = 1'b0;
    logic DEMOD_DATA = 1'b0, TONE_READY = 1'b0;
    logic DATA_IN, DATA_OUT, DATA_OE, RECOVERED_BIT_CLOCK, TONE_VALID, TONE_ONE;
    logic MOD_CLK_TICK, REG_RVALID, AMPLIFIER_ENABLE, AMPLIFIER_BYPASS, LOW_NOISE_AMP_SKIP;
    logic rx_bit, watch_rx = 1'b0, last_out, last_clk;
    logic [7:0] REG_RDATA;
    logic [2:0] AMPLIFIER_LEVEL;
    logic [3:0] FILTER_RSSI_BITS;
    int fail_count = 0, n_checks = 0, cycles = 0, i, j;
    logic [6:0] ra [7] = '{7'h00, 7'h01, 7'h06, 7'h07, 7'h15, 7'h16, 7'h02};
    logic [7:0] rv [7] = '{8'h01, 8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    logic [7:0] p6 [3] = '{8'h0E, 8'h0C, 8'h0E};
    logic [7:0] p7 [3] = '{8'h01, 8'h01, 8'h02};
    int pp [3] = '{16, 32, 32};
    int pt [3] = '{16, 32, 16};

    fsk_freq_error_bitsync_ctrl fsk_freq_error_bitsync_ctrl_i (
        .SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
        .UP_PULSE(UP_PULSE), .DOWN_PULSE(DOWN_PULSE), .DEMOD_DATA(DEMOD_DATA),
        .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
        .RECOVERED_BIT_CLOCK(RECOVERED_BIT_CLOCK), .TONE_VALID(TONE_VALID),
        .TONE_READY(TONE_READY), .TONE_ONE(TONE_ONE), .MOD_CLK_TICK(MOD_CLK_TICK),
        .AMPLIFIER_LEVEL(AMPLIFIER_LEVEL), .AMPLIFIER_ENABLE(AMPLIFIER_ENABLE),
        .AMPLIFIER_BYPASS(AMPLIFIER_BYPASS), .LOW_NOISE_AMP_SKIP(LOW_NOISE_AMP_SKIP),
        .FILTER_RSSI_BITS(FILTER_RSSI_BITS)
    );
    host_mcu_model host_mcu_model_i (
        .bit_clk(RECOVERED_BIT_CLOCK), .pin_oe(DATA_OE), .pin_out(DATA_OUT),
        .pin_level(DATA_IN), .rx_bit(rx_bit)
    );

    // 40 MHz system clock
    always #12.5 SYS_CLK = ~SYS_CLK;

    // hang guard, well above the expected run of about 4k cycles
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end

    // receive data must only move together with a rising recovered clock
    always @(posedge SYS_CLK) begin
        if (watch_rx && DATA_OUT !== last_out && !(RECOVERED_BIT_CLOCK && !last_clk)) begin
            fail_count++;
            $display("[ERR] rx data edge expected %b seen %b", last_out, DATA_OUT);
        end
        last_out <= DATA_OUT;
        last_clk <= RECOVERED_BIT_CLOCK;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask : tick

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // all tasks start and end 1 ns after a rising edge
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1'b1;
        tick(1);
        REG_WR = 1'b0;
        tick(1);
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string what);
        int k;
        REG_ADDR = a;
        REG_RD = 1'b1;
        tick(1);
        REG_RD = 1'b0;
        for (k = 0; k < 3 && REG_RVALID !== 1'b1; k++) tick(1);
        check("read valid", 8'h01, {7'h00, REG_RVALID});
        check(what, exp, REG_RDATA);
        tick(1);
    endtask : rd

    // pulses two cycles high, two low, ups first so none coincide
    task automatic pulses(input int nu, input int nd);
        int k;
        for (k = 0; k < nu + nd; k++) begin
            UP_PULSE = (k < nu);
            DOWN_PULSE = (k >= nu);
            tick(2);
            UP_PULSE = 1'b0;
            DOWN_PULSE = 1'b0;
            tick(2);
        end
    endtask : pulses

    task automatic est(input logic [7:0] ctrl, input int nu, input int nd, input int settle,
                       input logic [7:0] exp);
        wr(7'h15, ctrl);
        pulses(nu, nd);
        tick(settle);
        rd(7'h16, exp, "freq_error_count");
    endtask : est

    // cycles between two rising recovered clock edges, and modulator ticks among them
    task automatic period(input int exp_p, input int exp_t);
        int p, t;
        logic prev;
        p = 0;
        t = 0;
        prev = 1'b1;
        while (p < 300 && !(prev === 1'b0 && RECOVERED_BIT_CLOCK === 1'b1)) begin
            prev = RECOVERED_BIT_CLOCK;
            tick(1);
            p++;
        end
        p = 0;
        prev = 1'b1;
        while (p < 300 && !(prev === 1'b0 && RECOVERED_BIT_CLOCK === 1'b1)) begin
            prev = RECOVERED_BIT_CLOCK;
            if (MOD_CLK_TICK === 1'b1) t++;
            tick(1);
            p++;
        end
        check("bit clock period", exp_p[7:0], p[7:0]);
        check("mod clock ticks", exp_t[7:0], t[7:0]);
    endtask : period

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    initial begin
        tick(10);
        RST_N = 1'b1;
        for (i = 0; i < 7; i++) rd(ra[i], rv[i], "reset value");
        wr(7'h16, 8'h55);
        rd(7'h16, 8'h00, "read-only result");
        for (i = 0; i < 8; i++) begin
            wr(7'h00, {i[0], i[2:0], 4'h1});
            check("amp level", {5'h00, i[2:0]}, {5'h00, AMPLIFIER_LEVEL});
            check("amp enable", {7'h00, i != 0}, {7'h00, AMPLIFIER_ENABLE});
            check("lna skip", {7'h00, i[0]}, {7'h00, LOW_NOISE_AMP_SKIP});
        end
        check("amp bypass off", 8'h00, {7'h00, AMPLIFIER_BYPASS});
        wr(7'h06, 8'h80);
        check("amp bypass", 8'h01, {7'h00, AMPLIFIER_BYPASS});
        check("level in bypass", 8'h07, {5'h00, AMPLIFIER_LEVEL});
        wr(7'h01, 8'h0A);
        rd(7'h01, 8'h8A, "filter reg");
        check("filter bits", 8'h0A, {4'h0, FILTER_RSSI_BITS});
        // synchronous receive, period follows divider and shift
        wr(7'h00, 8'h0A);
        check("oe in receive", 8'h01, {7'h00, DATA_OE});
        for (i = 0; i < 3; i++) begin
            wr(7'h06, p6[i]);
            wr(7'h07, p7[i]);
            period(pp[i], pt[i]);
        end
        wr(7'h07, 8'h01);
        for (j = 0; j < 2; j++) begin
            DEMOD_DATA = ~DEMOD_DATA;
            tick(16);
            watch_rx = 1'b1;
            tick(22 * 16 + 48);
            watch_rx = 1'b0;
            check("host rx bit", {7'h00, DEMOD_DATA}, {7'h00, rx_bit});
        end
        // estimator in up, down and up-down modes and each length
        est(8'h01, 5, 3, 200, 8'h05);
        pulses(2, 2);
        rd(7'h16, 8'h05, "held count");
        est(8'h02, 2, 3, 200, 8'hFD);
        est(8'h07, 30, 10, 200, 8'h14);
        est(8'h0B, 100, 0, 300, 8'h64);
        est(8'h0F, 20, 149, 500, 8'h7F);
        rd(7'h15, 8'h0F, "estimator ctrl");
        wr(7'h15, 8'h00);
        // transmit: fill the tone fifo with the synthesizer stalled, then drain
        wr(7'h00, 8'h01); // idle first: the pin settles before the first push
        wr(7'h07, 8'hC1);
        wr(7'h00, 8'h05);
        check("oe in transmit", 8'h00, {7'h00, DATA_OE});
        tick(400);
        check("pushes when full", 8'h10, 8'(host_mcu_model_i.sent_q.size()));
        check("tone valid", 8'h01, {7'h00, TONE_VALID});
        for (i = 0; i < 16; i++) begin
            for (j = 0; j < 50 && TONE_VALID !== 1'b1; j++) tick(1);
            check("tone bit", {7'h00, host_mcu_model_i.sent_q[i]}, {7'h00, TONE_ONE});
            TONE_READY = 1'b1;
            tick(1);
            TONE_READY = 1'b0;
            tick(1);
        end
        final_report();
    end
endmodule : tb_top
`default_nettype wire
